//--- rtl/pbac_ctrl.sv
// pbac_ctrl: acknowledge, negative acknowledge, inhibit, hold, interrupt and
// subsystem reset logic of the peripheral subsystem port.
// assumes: pins from the subsystem are asynchronous; access status inputs come
// from port logic on pclk; apb master on pclk.
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module pbac_ctrl
    import pbac_pkg::*;
#(
    parameter int NWIN = PBAC_WINDOWS
) (
    // clock and reset
    input  wire logic            pclk,
    input  wire logic            presetn,
    // apb slave
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    // subsystem bus pins
    input  wire logic            latch_strobe,
    input  wire logic            output_enable,
    input  wire logic            access_qualify,
    input  wire logic            chip_select_n,
    input  wire logic            write_n,
    input  wire logic [NWIN-1:0] window_match,
    input  wire logic            hold_grant,
    // access status from port logic
    input  wire logic            access_valid,
    input  wire logic            buf_read_ready,
    input  wire logic            buf_write_space,
    input  wire logic            bus_data_valid,
    input  wire logic            buf_xfer_done,
    input  wire logic            sys_xfer_done,
    input  wire logic            access_fault,
    input  wire logic            interconnect_access,
    input  wire logic            interconnect_absent,
    // subsystem control pins
    output logic                 transfer_ack_n,
    output logic                 nak_n,
    output logic                 memory_inhibit,
    output logic                 bus_hold_request,
    output logic                 interrupt_out,
    output logic                 subsystem_reset_out,
    // pin readback for error detection
    input  wire logic            ack_pin_n,
    input  wire logic            nak_pin_n,
    input  wire logic            inhibit_pin,
    input  wire logic            interrupt_pin,
    input  wire logic            reset_pin,
    output logic                 hw_error
);

    // ==========================================================
    // types and state
    typedef enum logic [2:0] {
        PBAC_IDLE, PBAC_WAIT_SYNC, PBAC_DELAY, PBAC_WAIT_DONE,
        PBAC_NAK, PBAC_HOLD_ACK, PBAC_IGNORE
    } pbac_acc_t;

    typedef struct packed {
        logic [1:0]      delay_code;
        logic            phys_mode;
        logic            hold_req;
        logic            ss_reset;
        logic [NWIN-1:0] inh_en;
        logic [NWIN-1:0] buf_en;
        logic [NWIN-1:0] faulted;
        logic            grant_seen;
        logic            granted;
        logic            bypass;
        logic            herr_seen;
        logic [1:0]      int_cnt;
        logic            ack_en;
        logic [NWIN-1:0] win;
        logic            wr;
        logic            adv_wait;
        pbac_acc_t       acc;
        logic [1:0]      dly;
        logic            ack_n;
        logic            herr;
        logic            ale_q;
        logic            oe_q;
        logic            sync_q;
        logic [3:0]      exp_d1;
        logic [3:0]      exp_d2;
        logic            nak_d1;
        logic            nak_d2;
        logic [31:0]     rdata;
    } pbac_state_t;

    pbac_state_t st;
    pbac_state_t next_st;

    // ==========================================================
    // synchronised pins
    localparam int SW = NWIN + 11;
    logic [SW-1:0] pin_sync;
    logic          ale_s;
    logic          oe_s;
    logic          sync_s;
    logic          cs_n_s;
    logic          wr_n_s;
    logic [NWIN-1:0] win_s;
    logic          grant_s;
    logic [4:0]    rb_s;
    logic          nak_req;

    pbac_sync2 #(
        .WIDTH (SW)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({latch_strobe, output_enable, access_qualify, chip_select_n, write_n,
                    window_match, hold_grant, ack_pin_n, nak_pin_n, inhibit_pin,
                    interrupt_pin, reset_pin}),
        .sync_out (pin_sync)
    );

    assign {ale_s, oe_s, sync_s, cs_n_s, wr_n_s, win_s, grant_s, rb_s} = pin_sync;

    pbac_fall_launch u_nak (
        .pclk    (pclk),
        .presetn (presetn),
        .request (nak_req),
        .out_n   (nak_n)
    );

    assign nak_req = (st.acc == PBAC_NAK);

    // ==========================================================
    // helpers
    // minimum delay after sync
    function automatic logic [1:0] min_delay(input logic [1:0] code, input logic wr,
                                             input logic inh);
        logic [1:0] d;
        d = 2'h0;
        if (inh)
            d = PBAC_INH_MIN_CYCLES;
        else if (code == PBAC_DELAY_ONE)
            d = wr ? 2'h1 : 2'h0;
        else
            d = wr ? 2'h2 : 2'h1;
        return d;
    endfunction

    function automatic logic reg_hit(input logic [7:0] a);
        return (a == PBAC_CTRL_ADDR) || (a == PBAC_WINDOW_ADDR) ||
               (a == PBAC_STATUS_ADDR) || (a == PBAC_CMD_ADDR);
    endfunction

    // ==========================================================
    // combinational outputs
    // unclocked inhibit, gated by chip select
    assign memory_inhibit      = ~chip_select_n & (|(window_match & st.inh_en));
    assign pready              = 1'b1;
    assign pslverr             = psel & penable & ~reg_hit(paddr);
    assign prdata              = st.rdata;
    assign transfer_ack_n      = st.ack_n;
    assign bus_hold_request    = st.hold_req;
    assign interrupt_out       = |st.int_cnt;
    assign subsystem_reset_out = st.ss_reset;
    assign hw_error            = st.herr;

    // ==========================================================
    // next state
    logic ale_rise;
    logic ale_fall;
    logic oe_fall;
    logic sync_rise;
    logic apb_wr;
    logic apb_rd;
    logic buffered;
    logic inh_win;
    logic adv_ok;
    logic done;
    logic nak_cond;
    logic [3:0] exp_now;
    logic [3:0] obs;

    always_comb
    begin
        next_st   = st;
        ale_rise  = ale_s & ~st.ale_q;
        ale_fall  = ~ale_s & st.ale_q;
        oe_fall   = ~oe_s & st.oe_q;
        sync_rise = sync_s & ~st.sync_q;
        apb_wr    = psel & penable & pwrite;
        apb_rd    = psel & ~penable & ~pwrite;
        buffered  = |(st.win & st.buf_en);
        inh_win   = |(st.win & st.inh_en);
        adv_ok    = 1'b0;
        done      = 1'b0;
        nak_cond  = 1'b0;
        exp_now   = {st.ack_n, memory_inhibit, interrupt_out, st.ss_reset};
        obs       = {rb_s[4], rb_s[2], rb_s[1], rb_s[0]};

        next_st.ale_q  = ale_s;
        next_st.oe_q   = oe_s;
        next_st.sync_q = sync_s;
        next_st.herr   = 1'b0;

        // ------------------------------------------------------
        // acknowledge enable flop
        if (ale_rise)
            next_st.ack_en = 1'b1;

        unique case (st.acc)
            PBAC_IDLE:
            begin
                if (ale_fall && !cs_n_s && (|win_s))
                begin
                    next_st.win = win_s;
                    next_st.wr  = ~wr_n_s;
                    if (|(win_s & st.faulted))
                        next_st.acc = PBAC_IGNORE;
                    else
                        next_st.acc = PBAC_WAIT_SYNC;
                end
            end
            PBAC_WAIT_SYNC:
            begin
                // early ack only when valid and ready
                adv_ok = (st.delay_code == PBAC_DELAY_ADVANCED) && buffered && access_valid &&
                         (st.wr ? buf_write_space : buf_read_ready);
                if (adv_ok && st.ack_en)
                begin
                    next_st.ack_n = 1'b0;
                    next_st.acc   = PBAC_HOLD_ACK;
                end
                else if (sync_rise)
                begin
                    // late advanced ack waits for bus data
                    next_st.adv_wait = (st.delay_code == PBAC_DELAY_ADVANCED);
                    next_st.dly = (st.delay_code == PBAC_DELAY_ADVANCED) ? 2'h0 :
                                  min_delay(st.delay_code, st.wr, inh_win);
                    next_st.acc = PBAC_DELAY;
                end
            end
            PBAC_DELAY:
            begin
                if (st.dly == 2'h0)
                    next_st.acc = PBAC_WAIT_DONE;
                else
                    next_st.dly = st.dly - 2'h1;
            end
            PBAC_WAIT_DONE:
            begin
                nak_cond = access_fault ||
                           (st.phys_mode && interconnect_access && interconnect_absent);
                if (st.adv_wait)
                    done = bus_data_valid;
                else if (buffered)
                    done = buf_xfer_done;
                else
                    done = sys_xfer_done;
                if (nak_cond && st.ack_en)
                begin
                    next_st.acc = PBAC_NAK;
                    if (!buffered && !st.win[PBAC_UNFAULTABLE])
                        next_st.faulted = st.faulted | st.win;
                end
                else if (done && st.ack_en)
                begin
                    next_st.ack_n = 1'b0;
                    next_st.acc   = PBAC_HOLD_ACK;
                end
            end
            PBAC_NAK:
            begin
                // ack follows nak by half a clock
                next_st.ack_n = 1'b0;
                next_st.acc   = PBAC_HOLD_ACK;
            end
            PBAC_HOLD_ACK, PBAC_IGNORE:
            begin
                next_st.acc = st.acc;
            end
            default:
            begin
                next_st.acc = PBAC_IDLE;
            end
        endcase

        // output enable fall ends the access
        if (oe_fall)
        begin
            next_st.ack_en   = 1'b0;
            next_st.ack_n    = 1'b1;
            next_st.acc      = PBAC_IDLE;
        end

        // ------------------------------------------------------
        // hold interlock
        if (!st.hold_req)
        begin
            // grant high before request means bypass
            next_st.bypass     = grant_s;
            next_st.grant_seen = 1'b0;
            next_st.granted    = 1'b0;
        end
        else if (st.bypass)
            next_st.granted = 1'b1;
        else
        begin
            if (grant_s)
                next_st.grant_seen = 1'b1;
            if (sync_rise && (st.grant_seen || grant_s))
                next_st.granted = 1'b1;
        end

        // ------------------------------------------------------
        // interrupt pulse counter
        if (st.int_cnt != 2'h0)
            next_st.int_cnt = st.int_cnt - 2'h1;

        // ------------------------------------------------------
        // error detection: readback is two clocks behind the driven value
        next_st.exp_d1 = exp_now;
        next_st.exp_d2 = st.exp_d1;
        next_st.nak_d1 = nak_n;
        next_st.nak_d2 = st.nak_d1;
        // nak and first clock of sync
        if ((rb_s[3] != st.nak_d2) ||
            (sync_rise && (obs[3:2] != st.exp_d2[3:2])))
            next_st.herr = 1'b1;
        if (obs[1:0] != st.exp_d2[1:0])
            next_st.herr = 1'b1;
        if (st.herr)
            next_st.herr_seen = 1'b1;

        // ------------------------------------------------------
        // apb writes
        if (apb_wr)
        begin
            unique case (paddr)
                PBAC_CTRL_ADDR:
                begin
                    next_st.delay_code = pwdata[PBAC_CTRL_DELAY_LSB +: 2];
                    next_st.phys_mode  = pwdata[PBAC_CTRL_PHYS_BIT];
                    next_st.hold_req   = pwdata[PBAC_CTRL_HOLD_BIT];
                    next_st.ss_reset   = pwdata[PBAC_CTRL_SSRST_BIT];
                end
                PBAC_WINDOW_ADDR:
                begin
                    next_st.inh_en = pwdata[PBAC_WIN_INH_LSB +: NWIN];
                    next_st.buf_en = pwdata[PBAC_WIN_BUF_LSB +: NWIN];
                end
                PBAC_STATUS_ADDR:
                begin
                    // clear wins only where no new fault lands this cycle
                    next_st.faulted = next_st.faulted &
                                      ~(pwdata[PBAC_ST_FAULT_LSB +: NWIN] & st.faulted);
                    if (pwdata[PBAC_ST_HERR_BIT] && !st.herr)
                        next_st.herr_seen = 1'b0;
                end
                PBAC_CMD_ADDR:
                begin
                    if (pwdata[PBAC_CMD_INT_BIT])
                        next_st.int_cnt = PBAC_INT_CYCLES;
                end
                default:
                begin
                    next_st.rdata = st.rdata;
                end
            endcase
        end

        // ------------------------------------------------------
        // apb reads, captured in the setup cycle
        if (apb_rd)
        begin
            next_st.rdata = 32'h0000_0000;
            unique case (paddr)
                PBAC_CTRL_ADDR:
                begin
                    next_st.rdata[PBAC_CTRL_DELAY_LSB +: 2] = st.delay_code;
                    next_st.rdata[PBAC_CTRL_PHYS_BIT]       = st.phys_mode;
                    next_st.rdata[PBAC_CTRL_HOLD_BIT]       = st.hold_req;
                    next_st.rdata[PBAC_CTRL_SSRST_BIT]      = st.ss_reset;
                end
                PBAC_WINDOW_ADDR:
                begin
                    next_st.rdata[PBAC_WIN_INH_LSB +: NWIN] = st.inh_en;
                    next_st.rdata[PBAC_WIN_BUF_LSB +: NWIN] = st.buf_en;
                end
                PBAC_STATUS_ADDR:
                begin
                    next_st.rdata[PBAC_ST_FAULT_LSB +: NWIN] = st.faulted;
                    next_st.rdata[PBAC_ST_GRANT_BIT]         = st.granted;
                    next_st.rdata[PBAC_ST_BYPASS_BIT]        = st.bypass;
                    next_st.rdata[PBAC_ST_ILLEGAL_BIT]       = (st.delay_code == PBAC_DELAY_ILLEGAL);
                    next_st.rdata[PBAC_ST_BUSY_BIT]          = (st.acc != PBAC_IDLE);
                    next_st.rdata[PBAC_ST_HERR_BIT]          = st.herr_seen;
                end
                default:
                begin
                    next_st.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st            <= '0;
            st.delay_code <= PBAC_DELAY_RESET;
            st.inh_en     <= PBAC_INH_RESET[NWIN-1:0];
            st.buf_en     <= PBAC_BUF_RESET[NWIN-1:0];
            st.ack_n      <= 1'b1;
        end
        else
            st <= next_st;
    end

endmodule
`default_nettype wire

//--- include/pbac_pkg.sv
// pbac_pkg: register map, field layout, reset values and timing counts
// of the peripheral bus acknowledge control block.
// assumes: a 32-bit apb slave at 25 mhz, word-aligned registers.
package pbac_pkg;

    // ==========================================================
    // register byte addresses
    localparam logic [7:0] PBAC_CTRL_ADDR   = 8'h00;
    localparam logic [7:0] PBAC_WINDOW_ADDR = 8'h04;
    localparam logic [7:0] PBAC_STATUS_ADDR = 8'h08;
    localparam logic [7:0] PBAC_CMD_ADDR    = 8'h0c;

    // ==========================================================
    // ctrl fields
    localparam int PBAC_CTRL_DELAY_LSB  = 0;
    localparam int PBAC_CTRL_PHYS_BIT   = 2;
    localparam int PBAC_CTRL_HOLD_BIT   = 3;
    localparam int PBAC_CTRL_SSRST_BIT  = 4;
    // window fields
    localparam int PBAC_WIN_INH_LSB     = 0;
    localparam int PBAC_WIN_BUF_LSB     = 8;
    // status fields
    localparam int PBAC_ST_FAULT_LSB    = 0;
    localparam int PBAC_ST_GRANT_BIT    = 8;
    localparam int PBAC_ST_BYPASS_BIT   = 9;
    localparam int PBAC_ST_ILLEGAL_BIT  = 10;
    localparam int PBAC_ST_BUSY_BIT     = 11;
    localparam int PBAC_ST_HERR_BIT     = 12;
    // cmd fields
    localparam int PBAC_CMD_INT_BIT     = 0;

    // ==========================================================
    // reset values and codes
    localparam logic [1:0] PBAC_DELAY_ADVANCED = 2'h0;
    localparam logic [1:0] PBAC_DELAY_ONE      = 2'h1;
    localparam logic [1:0] PBAC_DELAY_TWO      = 2'h2;
    localparam logic [1:0] PBAC_DELAY_ILLEGAL  = 2'h3;
    localparam logic [1:0] PBAC_DELAY_RESET    = 2'h2;
    localparam logic [4:0] PBAC_INH_RESET      = 5'h00;
    localparam logic [4:0] PBAC_BUF_RESET      = 5'h00;
    localparam int         PBAC_WINDOWS        = 5;
    localparam int         PBAC_UNFAULTABLE    = 4;

    // ==========================================================
    // timing counts, in primary clock cycles
    localparam logic [1:0] PBAC_INT_CYCLES     = 2'h2;
    localparam logic [1:0] PBAC_INH_MIN_CYCLES = 2'h2;

endpackage

//--- rtl/pbac_sync2.sv
// pbac_sync2: two-flop synchroniser for a bundle of level inputs.
// assumes: each bit is an independent slow level or pulse of at least two clocks.
`timescale 1ns/100ps
`default_nettype none
module pbac_sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta     <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule
`default_nettype wire

//--- rtl/pbac_fall_launch.sv
// pbac_fall_launch: active-low output launched from the falling clock edge.
// assumes: request is a posedge-registered level; output idles high.
`timescale 1ns/100ps
`default_nettype none
module pbac_fall_launch (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // request and pin
    input  wire logic request,
    output logic      out_n
);
    always_ff @(negedge pclk or negedge presetn)
    begin
        if (!presetn)
            out_n <= 1'b1;
        else
            out_n <= ~request;
    end
endmodule
`default_nettype wire

//--- testbench/pbac_ctrl_asserts.sv
// pbac_ctrl_asserts: temporal checks on the pbac_ctrl ports.
// assumes: bound into pbac_ctrl, one clock pclk.
`timescale 1ns/100ps
`default_nettype none
module pbac_ctrl_asserts #(
    parameter int NWIN = 5
) (
    // watched ports
    input wire logic            pclk, presetn, psel, penable, pwrite, pslverr,
    input wire logic [7:0]      paddr,
    input wire logic [31:0]     pwdata,
    input wire logic            chip_select_n, output_enable, transfer_ack_n, nak_n, memory_inhibit,
    input wire logic            bus_hold_request, interrupt_out, subsystem_reset_out,
    input wire logic [NWIN-1:0] window_match
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr_go;
    assign wr_go = psel && penable && pwrite;
    // ========
    // properties
    int_width_a: assert property ($rose(interrupt_out) |=> interrupt_out ##1 !interrupt_out)
        else $error("interrupt width wrong");
    cmd_int_a: assert property (wr_go && paddr == 8'h0c && pwdata[0] |=> interrupt_out[*2])
        else $error("interrupt not raised");
    nak_width_a: assert property ($fell(nak_n) |=> nak_n)
        else $error("nak width wrong");
    nak_ack_a: assert property ($fell(nak_n) |=> $fell(transfer_ack_n))
        else $error("ack not after nak");
    inh_gate_a: assert property (chip_select_n || !(|window_match) |-> !memory_inhibit)
        else $error("inhibit not gated");
    rst_out_a: assert property (wr_go && paddr == 8'h00 |=> subsystem_reset_out == $past(pwdata[4]))
        else $error("reset out wrong");
    hold_out_a: assert property (wr_go && paddr == 8'h00 |=> bus_hold_request == $past(pwdata[3]))
        else $error("hold request wrong");
    ack_end_a: assert property ($fell(output_enable) |-> ##[1:5] transfer_ack_n)
        else $error("ack not ended");
    err_phase_a: assert property (pslverr |-> psel && penable)
        else $error("error outside access");
    cover property ($fell(nak_n));
    cover property ($fell(transfer_ack_n));
    cover property (memory_inhibit);
endmodule
bind pbac_ctrl pbac_ctrl_asserts #(.NWIN(NWIN)) chk (.pclk, .presetn, .psel, .penable, .pwrite, .pslverr,
    .paddr, .pwdata, .chip_select_n, .output_enable, .transfer_ack_n, .nak_n, .memory_inhibit,
    .bus_hold_request, .interrupt_out, .subsystem_reset_out, .window_match);
`default_nettype wire

//--- testbench/pbac_sub_master.sv
// pbac_sub_master: behavioural subsystem bus master on the port pins.
// assumes: the bench calls its tasks; pins idle deselected.
`timescale 1ns/100ps
`default_nettype none
module pbac_sub_master (
    // clock and answers
    input wire logic   pclk, transfer_ack_n, nak_n,
    // subsystem pins
    output logic       latch_strobe, output_enable, access_qualify, chip_select_n, write_n, hold_grant,
    output logic [4:0] window_match
);
    logic saw_nak;
    initial
    begin
        {latch_strobe, output_enable, access_qualify, hold_grant, saw_nak} = 5'h00;
        {chip_select_n, write_n, window_match} = 7'h60;
    end
    task automatic pins(input logic cs_n, input logic [4:0] w);
        @(posedge pclk);
        {chip_select_n, window_match} <= {cs_n, w};
    endtask
    task automatic access(input logic wr, input logic [4:0] w, output int lat);
        @(posedge pclk);
        {chip_select_n, write_n, window_match, latch_strobe} <= {1'h0, !wr, w, 1'h1};
        repeat (3) @(posedge pclk);
        latch_strobe <= 1'h0;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        access_qualify <= 1'h1;
        saw_nak = 1'h0;
        lat = 0;
        @(posedge pclk);
        while (transfer_ack_n !== 1'h0 && lat < 30)
        begin
            saw_nak |= (nak_n === 1'h0);
            lat++;
            @(posedge pclk);
        end
        {access_qualify, output_enable} <= 2'h1;
        repeat (2) @(posedge pclk);
        {output_enable, chip_select_n, window_match} <= 7'h20;
        repeat (6) @(posedge pclk);
    endtask
    task automatic grant();
        @(posedge pclk);
        hold_grant <= 1'h1;
        repeat (2) @(posedge pclk);
        hold_grant <= 1'h0;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        access_qualify <= 1'h1;
        repeat (3) @(posedge pclk);
        access_qualify <= 1'h0;
    endtask
endmodule
`default_nettype wire

//--- testbench/peripheral_bus_ack_control_test.sv
// peripheral_bus_ack_control_test: self-checking bench for pbac_ctrl.
// assumes: pbac_sub_master drives the subsystem pins, apb driven here.
`timescale 1ns/100ps
`default_nettype none
module peripheral_bus_ack_control_test;
    import pbac_pkg::*;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, fault = 1'h0, icx = 1'h0;
    logic rdy = 1'h1, e, pready, pslverr, latch_strobe, output_enable, access_qualify, chip_select_n, write_n;
    logic hold_grant, transfer_ack_n, nak_n, memory_inhibit, bus_hold_request, interrupt_out;
    logic subsystem_reset_out, hw_error;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [4:0] window_match;
    int err_total = 0, n_tests = 0, lat[8];
    pbac_ctrl uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .latch_strobe, .output_enable, .access_qualify, .chip_select_n, .write_n, .window_match, .hold_grant,
        .access_valid(rdy), .buf_read_ready(rdy), .buf_write_space(rdy), .bus_data_valid(rdy),
        .buf_xfer_done(rdy), .sys_xfer_done(rdy), .access_fault(fault), .interconnect_access(icx),
        .interconnect_absent(icx), .transfer_ack_n, .nak_n, .memory_inhibit, .bus_hold_request,
        .interrupt_out, .subsystem_reset_out, .ack_pin_n(transfer_ack_n), .nak_pin_n(nak_n),
        .inhibit_pin(memory_inhibit), .interrupt_pin(interrupt_out), .reset_pin(subsystem_reset_out), .hw_error);
    pbac_sub_master m (.pclk, .transfer_ack_n, .nak_n, .latch_strobe, .output_enable, .access_qualify,
        .chip_select_n, .write_n, .hold_grant, .window_match);
    initial forever #20 pclk = ~pclk;
    // ========
    // shared tasks
    task automatic results();
        $display("checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1)
        begin
            err_total++;
            results();
        end
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    // ========
    // scenarios
    task automatic t_regs();
        apb(1'h0, PBAC_CTRL_ADDR, 32'h0);
        chk(q, 32'h2, "delay code reset");
        apb(1'h0, 8'h10, 32'h0);
        chk({q, e}, 33'h1, "unmapped read");
    endtask
    task automatic t_int();
        apb(1'h1, PBAC_CMD_ADDR, 32'h1);
        for (int k = 0; k < 3; k++)
        begin
            @(negedge pclk);
            chk(interrupt_out, k < 2, "interrupt");
        end
    endtask
    task automatic t_inh();
        apb(1'h1, PBAC_WINDOW_ADDR, 32'h8);
        for (int k = 0; k < 4; k++)
        begin
            m.pins(k[0], k[1] ? 5'h08 : 5'h04);
            @(negedge pclk);
            chk(memory_inhibit, !k[0] && k[1], "inhibit");
        end
        m.pins(1'h1, 5'h00);
    endtask
    task automatic t_delay();
        for (int k = 0; k < 8; k++)
        begin
            apb(1'h1, PBAC_WINDOW_ADDR, k[2] ? 32'h2 : 32'h0);
            apb(1'h1, PBAC_CTRL_ADDR, k[1] ? 32'h2 : 32'h1);
            m.access(k[0], 5'h02, lat[k]);
        end
        for (int k = 1; k < 8; k++)
            chk(lat[k] - lat[0], k[2] ? 2 : k[1] + k[0], "ack delay");
        apb(1'h1, PBAC_WINDOW_ADDR, 32'h200);
        apb(1'h1, PBAC_CTRL_ADDR, 32'h0);
        m.access(1'h0, 5'h02, lat[1]);
        chk(lat[1] < lat[0], 1'h1, "adv ack");
        rdy <= 1'h0;
        m.access(1'h0, 5'h02, lat[1]);
        chk(lat[1], 30, "held ack");
    endtask
    task automatic t_ctrl();
        apb(1'h1, PBAC_CTRL_ADDR, 32'h1a);
        @(negedge pclk);
        chk({bus_hold_request, subsystem_reset_out}, 2'h3, "hold and reset");
        m.grant();
        apb(1'h0, PBAC_STATUS_ADDR, 32'h0);
        chk(q[9:8], 2'h1, "hold granted");
        apb(1'h1, PBAC_CTRL_ADDR, 32'h2);
    endtask
    task automatic t_fault();
        fault <= 1'h1;
        m.access(1'h0, 5'h04, lat[0]);
        chk(m.saw_nak, 1'h1, "nak");
        fault <= 1'h0;
        apb(1'h0, PBAC_STATUS_ADDR, 32'h0);
        chk({hw_error, q[12], q[4:0]}, 7'h04, "faulted window");
        m.access(1'h0, 5'h04, lat[0]);
        chk(lat[0], 30, "faulted window ignored");
        apb(1'h1, PBAC_CTRL_ADDR, 32'h6);
        icx <= 1'h1;
        m.access(1'h0, 5'h10, lat[0]);
        chk(m.saw_nak, 1'h1, "interconnect nak");
        icx <= 1'h0;
        m.access(1'h0, 5'h10, lat[0]);
        chk(lat[0] < 30, 1'h1, "window four acked");
    endtask
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        t_regs();
        t_int();
        t_inh();
        t_ctrl();
        t_fault();
        t_delay();
        results();
    end
    initial
    begin
        repeat (20000) @(posedge pclk);
        err_total++;
        results();
    end
endmodule
`default_nettype wire
